//--- core/fsrs_sequencer.v
// suspend/resume, software reset and parameter header sequencer of a serial flash
`include "fsrs_map.vh"
`timescale 1ns/1ns
`default_nettype none
module fsrs_sequencer #(
  parameter [7:0]  MAKER_ID   = 8'h5E,       // arbitrary maker code
  parameter [31:0] RESUME_CYC = `FSRS_RESUME_CYC
) (
  // system
  input  wire        clk_sys,
  input  wire        rst,
  // serial link
  input  wire        linkClk,
  input  wire        csN,
  input  wire [3:0]  ioIn,
  output reg  [3:0]  ioOut,
  output reg  [3:0]  ioOe,
  // mode and array operation
  input  wire        quadMode,
  input  wire        perfReadMode,
  input  wire        opStart,
  input  wire        opIsErase,
  input  wire        opIsSector,
  input  wire        opDone,
  input  wire        writeLatchSetIn,
  // status and array control
  output reg         busy,
  output reg  [7:0]  securityStatus,
  output reg         write_enable_latch,
  output reg         opHold,
  output reg         opAbort,
  output reg         regionUndefined,
  output reg         resetPulse
);
  // synchronisers for pins
  reg [1:0] sClk_reg, sCs_reg;
  reg [3:0] sIo1_reg, sIo2_reg;
  reg       clkPrev_reg;
  always @(posedge clk_sys) begin
    sClk_reg    <= {sClk_reg[0], linkClk};
    sCs_reg     <= {sCs_reg[0], csN};
    sIo1_reg    <= ioIn;
    sIo2_reg    <= sIo1_reg;
    clkPrev_reg <= sClk_reg[1];
  end
  wire rise   = sClk_reg[1] & ~clkPrev_reg;
  wire fall   = ~sClk_reg[1] & clkPrev_reg;
  wire csHigh = sCs_reg[1];

  // parameter header lookup
  function [7:0] tblByte;
    input [4:0] a;
    input [7:0] maker;
    begin
      case (a)
        5'h00: tblByte = 8'h53;
        5'h01: tblByte = 8'h46;
        5'h02: tblByte = 8'h44;
        5'h03: tblByte = 8'h50;
        5'h04: tblByte = 8'h00;
        5'h05: tblByte = 8'h01;
        5'h06: tblByte = 8'h01;
        5'h08: tblByte = 8'h00;
        5'h09: tblByte = 8'h00;
        5'h0A: tblByte = 8'h01;
        5'h0B: tblByte = 8'h09;
        5'h0C: tblByte = 8'h30;
        5'h0D: tblByte = 8'h00;
        5'h0E: tblByte = 8'h00;
        5'h10: tblByte = maker;
        5'h11: tblByte = 8'h00;
        5'h12: tblByte = 8'h01;
        5'h13: tblByte = 8'h04;
        5'h14: tblByte = 8'h60;
        5'h15: tblByte = 8'h00;
        5'h16: tblByte = 8'h00;
        default: tblByte = `FSRS_PAD;
      endcase
    end
  endfunction

  // opcode filter while suspended
  function allowed;
    input [7:0] op;
    begin
      case (op)
        8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB, 8'h5A, 8'hC0, 8'h06, 8'h04, 8'h2B,
        8'h9F, 8'hAF, 8'h05, 8'hAB, 8'h90, 8'hB1, 8'hC1, 8'hB0, 8'h30, 8'h66, 8'h99,
        8'h00, 8'h35, 8'hF5, 8'h15, 8'h2D, 8'h27, 8'hA7, 8'hE2, 8'hE0, 8'h16: allowed = 1'b1;
        default: allowed = 1'b0;
      endcase
    end
  endfunction

  // frame shifter: bits per link clock depend on mode
  reg [7:0]  shift_reg;
  reg [2:0]  bitCnt_reg;
  reg [2:0]  byteCnt_reg;
  reg        inFrame_reg;
  reg [7:0]  opcode_reg;
  reg        opValid_reg;
  reg        isTable_reg;
  reg [23:0] addr_reg;
  reg [7:0]  outByte_reg;
  reg        byteDone;
  reg [7:0]  shiftNext;
  always @* begin
    byteDone  = 1'b0;
    shiftNext = shift_reg;
    if (rise) begin
      if (quadMode) begin
        shiftNext = {shift_reg[3:0], sIo2_reg};
        byteDone  = bitCnt_reg == 3'h1;
      end else begin
        shiftNext = {shift_reg[6:0], sIo2_reg[0]}; // upper lines ignored
        byteDone  = bitCnt_reg == 3'h7;
      end
    end
  end

  wire wholeByte = inFrame_reg & byteDone;
  wire opByte    = wholeByte & (byteCnt_reg == 3'h0);
  // opcode known at frame end, committed only on a byte boundary
  wire frameEnd  = csHigh & inFrame_reg & opValid_reg & (bitCnt_reg == 3'h0);

  always @(posedge clk_sys) begin
    if (rst | csHigh) begin
      shift_reg   <= 8'h00;
      bitCnt_reg  <= 3'h0;
      byteCnt_reg <= 3'h0;
      isTable_reg <= 1'b0;
      ioOe        <= 4'h0;
      ioOut       <= 4'h0;
      inFrame_reg <= ~rst & ~csHigh;
      if (rst)
        opValid_reg <= 1'b0;
      else if (frameEnd | ~inFrame_reg)
        opValid_reg <= 1'b0;
      if (rst) begin
        opcode_reg <= 8'h00;
        addr_reg   <= 24'h000000;
        outByte_reg <= 8'h00;
      end
    end else begin
      inFrame_reg <= 1'b1;
      shift_reg   <= shiftNext;
      if (rise)
        bitCnt_reg <= quadMode ? (bitCnt_reg == 3'h1 ? 3'h0 : 3'h1) : bitCnt_reg + 3'h1;
      if (wholeByte) begin
        if (byteCnt_reg != `FSRS_DUMMY_END)
          byteCnt_reg <= byteCnt_reg + 3'h1;
        if (opByte) begin
          opcode_reg  <= shiftNext;
          opValid_reg <= 1'b1;
          isTable_reg <= shiftNext == `FSRS_OP_TABLE;
        end else if (isTable_reg & (byteCnt_reg <= `FSRS_ADDR_BYTES)) begin
          addr_reg <= {addr_reg[15:0], shiftNext};
        end else if (isTable_reg) begin
          // dummy byte or data: load next output byte
          // beyond the header window every byte reads as pad, not a wrapped copy
          outByte_reg <= (addr_reg[23:5] == 19'h0) ? tblByte(addr_reg[4:0], MAKER_ID) : `FSRS_PAD;
          addr_reg    <= (addr_reg[23:5] == 19'h0) ? addr_reg + 24'h1 : addr_reg;
        end
      end
      // drive data out on falling edges from the dummy byte onward
      if (isTable_reg & (byteCnt_reg == `FSRS_DUMMY_END) & fall) begin
        if (quadMode) begin
          ioOe  <= 4'hF;
          ioOut <= bitCnt_reg == 3'h0 ? outByte_reg[7:4] : outByte_reg[3:0];
        end else begin
          ioOe  <= 4'h2;
          ioOut <= {2'b00, outByte_reg[3'h7 - bitCnt_reg], 1'b0};
        end
      end
    end
  end

  // operation state machine
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_RUN  = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_SUSP = 4'b1000;
  reg  [3:0]  state_reg;
  reg         isErase_reg, sectorEr_reg, armed_reg;
  reg  [31:0] runCnt_reg, resumeCnt_reg, recov_reg;
  wire        cmdNow  = frameEnd & (state_reg != ST_SUSP | allowed(opcode_reg));
  wire        eraseOk = ~sectorEr_reg | (runCnt_reg >= `FSRS_SUSP_CYC);
  always @(posedge clk_sys) begin
    opAbort    <= 1'b0;
    resetPulse <= 1'b0;
    if (rst) begin
      state_reg          <= ST_IDLE;
      isErase_reg        <= 1'b0;
      sectorEr_reg       <= 1'b0;
      armed_reg          <= 1'b0;
      runCnt_reg         <= 32'h0;
      resumeCnt_reg      <= 32'h0;
      recov_reg          <= 32'h0;
      securityStatus     <= 8'h00;
      write_enable_latch <= 1'b0;
      busy               <= 1'b0;
      opHold             <= 1'b0;
      regionUndefined    <= 1'b0;
    end else begin
      if (resumeCnt_reg != 32'h0)
        resumeCnt_reg <= resumeCnt_reg - 32'h1;
      if (recov_reg != 32'h0)
        recov_reg <= recov_reg - 32'h1;
      if (state_reg == ST_RUN || state_reg == ST_WAIT)
        runCnt_reg <= runCnt_reg + 32'h1;
      // reset arm bookkeeping: any other accepted command drops it
      if (cmdNow)
        armed_reg <= opcode_reg == `FSRS_OP_RSTARM;
      if (writeLatchSetIn | (cmdNow & opcode_reg == `FSRS_OP_WLSET))
        write_enable_latch <= 1'b1;
      // still busy while a suspend waits for its latency to run out
      busy <= (state_reg == ST_RUN) | (state_reg == ST_WAIT) | (recov_reg > 32'h1);
      case (state_reg)
        ST_IDLE: begin
          if (opStart) begin
            state_reg    <= ST_RUN;
            isErase_reg  <= opIsErase;
            sectorEr_reg <= opIsErase & opIsSector;
            runCnt_reg   <= 32'h0;
          end
        end
        ST_RUN: begin
          if (opDone)
            state_reg <= ST_IDLE;
          else if (cmdNow & opcode_reg == `FSRS_OP_SUSP)
            state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          // hold the array within the suspend latency
          if (eraseOk) begin
            state_reg          <= ST_SUSP;
            opHold             <= 1'b1;
            write_enable_latch <= 1'b0;
            regionUndefined    <= 1'b1;
            securityStatus[`FSRS_SEC_ESUSP] <= isErase_reg;
            securityStatus[`FSRS_SEC_PSUSP] <= ~isErase_reg;
          end
        end
        ST_SUSP: begin
          if (cmdNow & opcode_reg == `FSRS_OP_RESUME & ~perfReadMode) begin
            state_reg       <= ST_RUN;
            opHold          <= 1'b0;
            regionUndefined <= 1'b0;
            resumeCnt_reg   <= RESUME_CYC;
            securityStatus[`FSRS_SEC_ESUSP] <= 1'b0;
            securityStatus[`FSRS_SEC_PSUSP] <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      // software reset wins over everything else
      if (cmdNow & opcode_reg == `FSRS_OP_RESET & armed_reg) begin
        state_reg          <= ST_IDLE;
        opAbort            <= state_reg != ST_IDLE;
        resetPulse         <= 1'b1;
        armed_reg          <= 1'b0;
        securityStatus     <= 8'h00;
        write_enable_latch <= 1'b0;
        opHold             <= 1'b0;
        regionUndefined    <= 1'b0;
        busy               <= 1'b1;
        recov_reg          <= (state_reg != ST_IDLE) ? {24'h0, `FSRS_RECOV_CYC} << 2 : {24'h0, `FSRS_RECOV_CYC};
      end
    end
  end
endmodule // fsrs_sequencer
`default_nettype wire

//--- core/fsrs_map.vh
// constants for the suspend, reset and parameter table sequencer
`ifndef FSRS_MAP_VH
`define FSRS_MAP_VH
// opcodes
`define FSRS_OP_RESUME   8'h30
`define FSRS_OP_RSTARM   8'h66
`define FSRS_OP_RESET    8'h99
`define FSRS_OP_NOP      8'h00
`define FSRS_OP_TABLE    8'h5A
`define FSRS_OP_SUSP     8'hB0
`define FSRS_OP_WLSET    8'h06
`define FSRS_OP_PEXIT    8'hFF
// status bit positions
`define FSRS_SEC_PSUSP   2
`define FSRS_SEC_ESUSP   3
// frame byte counts
`define FSRS_ADDR_BYTES  3'h3
`define FSRS_DUMMY_END   3'h4
// timing: clock rate and times
`define FSRS_CLK_MHZ     20
`define FSRS_SUSP_US     20
`define FSRS_SUSP_CYC    (`FSRS_SUSP_US * `FSRS_CLK_MHZ)
`define FSRS_RESUME_US   1000
`define FSRS_RESUME_CYC  (`FSRS_RESUME_US * `FSRS_CLK_MHZ)
`define FSRS_RECOV_CYC   8'h10
// table bytes
`define FSRS_TBL_LAST    5'h17
`define FSRS_PAD         8'hFF
`endif

//--- bench/fsrs_seq_checker.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ns
`default_nettype none
module fsrs_seq_checker (
  // system
  input wire logic       clk_sys,
  input wire logic       rst,
  // inputs
  input wire logic       perfReadMode,
  input wire logic       opStart,
  input wire logic       opIsErase,
  input wire logic       opIsSector,
  // outputs
  input wire logic       busy,
  input wire logic [7:0] securityStatus,
  input wire logic       write_enable_latch,
  input wire logic       opHold,
  input wire logic       opAbort,
  input wire logic       regionUndefined,
  input wire logic       resetPulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] ageReg;
  logic        sectReg;
  // age of the running array operation, saturating
  always_ff @(posedge clk_sys) begin
    if (rst || opStart) begin
      ageReg  <= 16'h0;
      sectReg <= opStart & opIsErase & opIsSector;
    end else if (ageReg != 16'hFFFF) begin
      ageReg <= ageReg + 16'h1;
    end
  end
  sequence s_rstSeen;
    resetPulse ##[0:2] busy;
  endsequence
  a_sect_wait: assert property ($rose(securityStatus[3]) && sectReg |-> ageReg >= 16'h18F)
    else $error("erase suspended too early");
  a_susp_ready: assert property ($rose(securityStatus[2]) || $rose(securityStatus[3])
    |-> ##[0:2] (opHold && regionUndefined)) else $error("suspend without hold");
  a_latch_clear: assert property ($rose(securityStatus[3:2] != 2'h0) |-> ##[0:2] !write_enable_latch)
    else $error("latch kept on suspend");
  a_resume_gate: assert property ($fell(securityStatus[3]) && !resetPulse && !$past(resetPulse)
    |-> !$past(perfReadMode)) else $error("resume in performance mode");
  a_abort_pulse: assert property (opAbort |=> !opAbort) else $error("abort too long");
  a_reset_recover: assert property (s_rstSeen |=> busy [*8]) else $error("recovery too short");
  a_reset_clears: assert property (resetPulse |-> ##[0:3] (securityStatus == 8'h00 && !opHold))
    else $error("reset left state");
  a_idle_ignore: assert property (!busy && securityStatus[3:2] == 2'h0 |=> securityStatus[3:2] == 2'h0)
    else $error("idle suspend took effect");
endmodule // fsrs_seq_checker
bind fsrs_sequencer fsrs_seq_checker chk (.clk_sys(clk_sys), .rst(rst), .perfReadMode(perfReadMode),
  .opStart(opStart), .opIsErase(opIsErase), .opIsSector(opIsSector), .busy(busy),
  .securityStatus(securityStatus), .write_enable_latch(write_enable_latch), .opHold(opHold),
  .opAbort(opAbort), .regionUndefined(regionUndefined), .resetPulse(resetPulse));
`default_nettype wire

//--- bench/fsrs_host_model.sv
// host controller model driving the serial link
`timescale 1ns/1ns
`default_nettype none
module fsrs_host_model (
  // serial link
  output logic            linkClk,
  output logic            csN,
  output logic      [3:0] ioIn,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOe,
  input  wire logic       quadMode
);
  logic [7:0] rdQ[$];
  // link idles with clock low and deselected
  initial begin
    linkClk = 1'b0;
    csN = 1'b1;
    ioIn = 4'h5;
  end
  // one byte out, device bit taken at each rise
  task automatic xb(input logic [7:0] d);
    logic [7:0] q;
    q = 8'h00;
    for (int i = 7; i >= 0; i -= (quadMode ? 4 : 1)) begin
      ioIn = quadMode ? d[i -: 4] : {~ioIn[3:1], d[i]};
      #200 linkClk = 1'b1;
      // a released data line floats to its pull-up level
      q = {q[6:0], ioOe[1] ? ioOut[1] : 1'b1};
      #200 linkClk = 1'b0;
    end
    rdQ.push_back(q);
  endtask
  // opcode, address and dummy bytes, then reads
  task automatic frame(input logic [7:0] op, input int nAd, input logic [31:0] ad, input int nRd);
    csN = 1'b0;
    xb(op);
    for (int k = 0; k < nAd; k++) xb(ad[31 - 8 * k -: 8]);
    rdQ = {};
    repeat (nRd) xb(8'h00);
    #200 csN = 1'b1;
    ioIn = ~ioIn;
    #800;
  endtask
endmodule // fsrs_host_model
`default_nettype wire

//--- bench/test_fsrs_sequencer.sv
// self-checking bench for the sequencer
`timescale 1ns/1ns
`default_nettype none
`include "fsrs_map.vh"
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin errCount++; $display("Error %s exp %0h got %0h", n, e, g); end end
`define WAITC(c,n) begin w = 0; while ((c) !== 1'b1 && w < (n)) begin @(negedge clk_sys); w++; end if ((c) !== 1'b1) begin errCount++; tally_and_finish; end end
module test_fsrs_sequencer;
  localparam logic [7:0] MAKER = 8'hA7; // arbitrary maker code
  logic       clk_sys = 1'b0, rst = 1'b1, quadMode = 1'b0, perfReadMode = 1'b0, wlSet = 1'b0;
  logic       opStart = 1'b0, opIsErase = 1'b0, opIsSector = 1'b0, opDone = 1'b0;
  wire logic  linkClk, csN;
  wire logic  [3:0] ioIn;
  logic [3:0] ioOut, ioOe;
  logic       busy, latchOut, opHold, opAbort, regionUndefined, resetPulse;
  logic [7:0] securityStatus;
  int         errCount = 0, checked = 0, pulses = 0, aborts = 0, w, p;
  time        t0;
  logic [7:0] tbl[24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h09,
                          8'h30, 8'h00, 8'h00, 8'hFF, MAKER, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF};
  // clock and pulse counters
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (resetPulse === 1'b1) pulses++;
    if (opAbort === 1'b1) aborts++;
  end
  // resume spacing of 100 cycles; the sequencer counts it down but nothing waits on it
  fsrs_sequencer #(.MAKER_ID(MAKER), .RESUME_CYC(32'h64)) dut (.clk_sys(clk_sys), .rst(rst),
    .linkClk(linkClk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .quadMode(quadMode),
    .perfReadMode(perfReadMode), .opStart(opStart), .opIsErase(opIsErase), .opIsSector(opIsSector),
    .opDone(opDone), .writeLatchSetIn(wlSet), .busy(busy), .securityStatus(securityStatus),
    .write_enable_latch(latchOut), .opHold(opHold), .opAbort(opAbort), .regionUndefined(regionUndefined),
    .resetPulse(resetPulse));
  fsrs_host_model host (.linkClk(linkClk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .quadMode(quadMode));
  // verdict and end of run
  task automatic tally_and_finish;
    if (errCount == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one-cycle pulse on an array control input
  task automatic pulse(input int which, input logic er, input logic sec);
    @(negedge clk_sys);
    if (which == 0) {opStart, opIsErase, opIsSector} = {1'b1, er, sec};
    else opDone = 1'b1;
    @(negedge clk_sys);
    {opStart, opDone} = 2'h0;
    t0 = $time;
  endtask
  // a suspended program, then a reset pair
  task automatic suspendAndReset;
    pulse(0, 1'b0, 1'b0);
    host.frame(`FSRS_OP_SUSP, 0, 0, 0);
    `WAITC(securityStatus[`FSRS_SEC_PSUSP], 400)
    p = pulses;
    host.frame(`FSRS_OP_RSTARM, 0, 0, 0);
    host.frame(`FSRS_OP_RESET, 0, 0, 0);
    `CHK("reset pulse", p + 1, pulses)
    `CHK("status after reset", 8'h00, securityStatus)
    `CHK("recovery busy", 1'b1, busy)
    // no new command until the recovery time is over
    `WAITC(!busy, 200)
  endtask
  // watchdog
  initial begin
    #4000000;
    errCount++;
    tally_and_finish;
  end
  // main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    host.frame(`FSRS_OP_TABLE, 4, 32'h0, 25);
    foreach (tbl[i]) `CHK("table byte", tbl[i], host.rdQ[i])
    `CHK("past end", `FSRS_PAD, host.rdQ[24])
    @(negedge clk_sys) wlSet = 1'b1;
    @(negedge clk_sys) wlSet = 1'b0;
    suspendAndReset();
    pulse(0, 1'b0, 1'b0);
    @(negedge clk_sys) wlSet = 1'b1;
    @(negedge clk_sys) wlSet = 1'b0;
    host.frame(`FSRS_OP_SUSP, 0, 0, 0);
    `WAITC(securityStatus[`FSRS_SEC_PSUSP], 400)
    repeat (4) @(negedge clk_sys);
    `CHK("latch", 1'b0, latchOut)
    `CHK("hold region", 2'h3, {opHold, regionUndefined})
    host.frame(8'h20, 0, 0, 0);
    perfReadMode = 1'b1;
    host.frame(`FSRS_OP_RESUME, 0, 0, 0);
    `CHK("flags blocked", 8'h04, securityStatus)
    perfReadMode = 1'b0;
    host.frame(`FSRS_OP_RESUME, 0, 0, 0);
    `CHK("resumed", 3'h1, {securityStatus[`FSRS_SEC_PSUSP], opHold, busy})
    pulse(1, 1'b0, 1'b0);
    // host keeps the resume to suspend spacing
    repeat (100) @(negedge clk_sys);
    pulse(0, 1'b1, 1'b1);
    host.frame(`FSRS_OP_SUSP, 0, 0, 0);
    `WAITC(securityStatus[`FSRS_SEC_ESUSP], 500)
    `CHK("erase delay", 1'b1, ($time - t0) >= 20000 && ($time - t0) <= 25000)
    quadMode = 1'b1;
    host.frame(`FSRS_OP_RESUME, 0, 0, 0);
    `CHK("quad resume", 8'h00, securityStatus)
    quadMode = 1'b0;
    pulse(1, 1'b0, 1'b0);
    `WAITC(!busy, 100)
    host.frame(`FSRS_OP_SUSP, 0, 0, 0);
    `CHK("idle suspend", 8'h00, securityStatus)
    p = pulses;
    host.frame(`FSRS_OP_RSTARM, 0, 0, 0);
    host.frame(`FSRS_OP_NOP, 0, 0, 0);
    host.frame(`FSRS_OP_RESET, 0, 0, 0);
    `CHK("cancelled reset", p, pulses)
    p = aborts;
    suspendAndReset();
    `CHK("abort", p + 1, aborts)
    `WAITC(!busy, 200)
    tally_and_finish;
  end
endmodule // test_fsrs_sequencer
`default_nettype wire
